// >>> rtl/ssc_pkg.sv
// Constants, field positions and types of the synthesizer serial control block.
package ssc_pkg;

  localparam int CLK_MHZ     = 200;
  localparam int WORD_W      = 32;
  localparam int PAYLOAD_W   = 29;
  localparam int READ_BIT    = 31;
  localparam int ADDR_HI     = 2;

  localparam logic [2:0] ADDR_DIV_OUT   = 3'h0;
  localparam logic [2:0] ADDR_INT_PHASE = 3'h1;
  localparam logic [2:0] ADDR_REF_PUMP  = 3'h2;
  localparam logic [2:0] ADDR_MODE_PUMP = 3'h3;
  localparam logic [2:0] ADDR_TIMER_CONV = 3'h4;
  localparam logic [2:0] ADDR_CONV_RB   = 3'h6;

  // Register 0.
  localparam int OSEL_HI = 30, OSEL_LO = 27, NLO_HI = 26, NLO_LO = 15;
  localparam int FRAC_HI = 14, FRAC_LO = 3;
  // Register 1.
  localparam int NHI_HI = 30, NHI_LO = 27, RHI_HI = 19, RHI_LO = 15;
  localparam int PHASE_HI = 14, PHASE_LO = 3;
  // Register 2.
  localparam int NOISE_HI = 30, NOISE_LO = 29, PUMP_HI = 27, PUMP_LO = 24;
  localparam int LSPEED_BIT = 23, LPREC_BIT = 22, RHALF_BIT = 21, RDBL_BIT = 20;
  localparam int RLO_HI = 19, RLO_LO = 15;
  // Register 3.
  localparam int CLAMP_BIT = 13, INTSEL_BIT = 10, LDTYPE_BIT = 9, POL_BIT = 6;
  localparam int SOFT_POWERDOWN_BIT = 5, TRI_BIT = 4, HOLD_BIT = 3;
  // Register 4.
  localparam int AUTOINT_BIT = 29, DMODE_HI = 20, DMODE_LO = 19;
  localparam int DVAL_HI = 18, DVAL_LO = 7, CMODE_HI = 6, CMODE_LO = 4, CSTART_BIT = 3;
  // Register 6.
  localparam int TEMP_HI = 9, TEMP_LO = 3;

  localparam logic [3:0] OSEL_HIZ    = 4'h0;
  localparam logic [3:0] OSEL_HIGH   = 4'h1;
  localparam logic [3:0] OSEL_LOW    = 4'h2;
  localparam logic [3:0] OSEL_RDIV   = 4'h3;
  localparam logic [3:0] OSEL_NDIV   = 4'h4;
  localparam logic [3:0] OSEL_ALOCK  = 4'h5;
  localparam logic [3:0] OSEL_DLOCK  = 4'h6;
  localparam logic [3:0] OSEL_RDBACK = 4'h7;
  localparam logic [3:0] OSEL_SYNC   = 4'h8;
  localparam logic [3:0] OSEL_FAST   = 4'hc;
  localparam logic [3:0] OSEL_RHALF  = 4'hd;

  localparam logic [1:0] DMODE_OFF   = 2'h0;
  localparam logic [1:0] DMODE_FAST  = 2'h1;
  localparam logic [1:0] DMODE_PHASE = 2'h2;
  localparam logic [1:0] DMODE_CONV  = 2'h3;
  localparam logic [2:0] CMODE_TEMP  = 3'h1;
  localparam logic [3:0] PUMP_MIN    = 4'h0;
  localparam logic [3:0] PUMP_MAX    = 4'hf;

  localparam logic [5:0] LOCK_RUN_FRAC = 6'h28;
  localparam logic [5:0] LOCK_RUN_INT  = 6'h05;
  localparam logic [3:0] WIN_WIDE_NS   = 4'ha;
  localparam logic [3:0] WIN_NARROW_NS = 4'h6;
  localparam logic [3:0] WIN_FAST_NS   = 4'h4;
  localparam logic [3:0] UNLOCK_SLOW_NS = 4'hf;

  localparam int CONV_TIME_US    = 100;
  localparam int CONV_CYCLES_DEF = CONV_TIME_US * CLK_MHZ;

  localparam logic [4:0] RB_LAST = 5'h1c;

  localparam int PIN_SCLK = 0, PIN_SDATA = 1, PIN_LOAD = 2, PIN_CE = 3, PIN_MUX = 4;
  localparam int PIN_TICK = 5, PIN_LOCKED = 6, PIN_RDIV = 7, PIN_NDIV = 8, PIN_ALOCK = 9;
  localparam int NPINS = 10;

  typedef enum logic [1:0] {RB_IDLE, RB_ARMED, RB_SHIFT} ssc_rb_t;

  // True when a committed word is a write to the given address.
  function automatic logic ssc_write_hit(input logic [WORD_W-1:0] w, input logic [2:0] a);
    return !w[READ_BIT] && (w[ADDR_HI:0] == a);
  endfunction : ssc_write_hit

endpackage : ssc_pkg

// >>> rtl/ssc_serial_control.sv
// Serial programming, readback and control logic of the synthesizer.
module ssc_serial_control
  import ssc_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        serial_clock,
  input  wire logic        serial_data,
  input  wire logic        load_strobe,
  input  wire logic        chip_enable,
  input  wire logic        mux_in,
  output logic             mux_out,
  output logic             mux_oe,
  input  wire logic        detector_tick,
  input  wire logic        phase_locked,
  input  wire logic        ref_div_in,
  input  wire logic        fb_div_in,
  input  wire logic        analog_lock,
  input  wire logic [6:0]  temp_code,
  output logic             shutdown,
  output logic             ref_input_hiz,
  output logic             counter_hold,
  output logic             integer_mode,
  output logic             lock_detect_type,
  output logic             pump_hiz,
  output logic             detector_polarity,
  output logic             pump_clamp,
  output logic [3:0]       pump_current_code,
  output logic [1:0]       modulator_noise_mode,
  output logic             reference_doubler,
  output logic             reference_halver,
  output logic [9:0]       ref_divider,
  output logic [15:0]      feedback_int,
  output logic [11:0]      fraction,
  output logic [11:0]      phase_value,
  output logic             phase_apply,
  output logic             divider_resync,
  output logic             converter_clock_en,
  output logic             converter_busy,
  output logic             lock_detect,
  output logic [3:0]       lock_window_ns,
  output logic [3:0]       unlock_window_ns,
  output logic             fast_lock_active
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [NPINS-1:0] pins;
  logic [NPINS-1:0] lvl;
  logic [NPINS-1:0] rise;

  assign pins = {analog_lock, fb_div_in, ref_div_in, phase_locked, detector_tick,
                 mux_in, chip_enable, load_strobe, serial_data, serial_clock};

  for (genvar i = 0; i < NPINS; i++) begin : g_sync
    ssc_sync u_sync (
      .clk    (clk),
      .resetn (resetn),
      .pin    (pins[i]),
      .level  (lvl[i]),
      .rise   (rise[i])
    );
  end

  logic sclk_rise;
  logic commit;
  logic tick;

  assign sclk_rise = rise[PIN_SCLK];
  assign commit    = rise[PIN_LOAD];
  assign tick      = rise[PIN_TICK];

  // ==========================================================================
  // Shift register
  // ==========================================================================
  logic [WORD_W-1:0] shift_word;

  // A plain shift keeps only the newest 32 bits when the host overclocks.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shift_word <= '0;
    end else if (sclk_rise && !lvl[PIN_LOAD]) begin
      shift_word <= {shift_word[WORD_W-2:0], lvl[PIN_SDATA]};
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [WORD_W-1:0] reg_div_out;
  logic [WORD_W-1:0] reg_int_phase;
  logic [WORD_W-1:0] reg_ref_pump;
  logic [WORD_W-1:0] reg_mode_pump;
  logic [WORD_W-1:0] reg_timer_conv;
  logic [WORD_W-1:0] reg_conv_rb;
  logic [WORD_W-1:0] next_image;

  // Stored images keep the address and a cleared read bit, so readback is regular.
  assign next_image = {1'b0, shift_word[WORD_W-2:0]};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_div_out    <= '0;
      reg_int_phase  <= '0;
      reg_ref_pump   <= '0;
      reg_mode_pump  <= '0;
      reg_timer_conv <= '0;
    end else if (commit) begin
      // A read request carries a set read bit, so no register is touched.
      if (ssc_write_hit(shift_word, ADDR_DIV_OUT)) begin
        reg_div_out <= next_image;
      end
      if (ssc_write_hit(shift_word, ADDR_INT_PHASE)) begin
        reg_int_phase <= next_image;
      end
      if (ssc_write_hit(shift_word, ADDR_REF_PUMP)) begin
        reg_ref_pump <= next_image;
      end
      if (ssc_write_hit(shift_word, ADDR_MODE_PUMP)) begin
        reg_mode_pump <= next_image;
      end
      if (ssc_write_hit(shift_word, ADDR_TIMER_CONV)) begin
        reg_timer_conv <= next_image;
      end
    end
  end

  logic [3:0]  osel;
  logic [1:0]  dmode;
  logic [11:0] dval;
  logic        reg0_write;

  assign osel       = reg_div_out[OSEL_HI:OSEL_LO];
  assign dmode      = reg_timer_conv[DMODE_HI:DMODE_LO];
  assign dval       = reg_timer_conv[DVAL_HI:DVAL_LO];
  assign reg0_write = commit && ssc_write_hit(shift_word, ADDR_DIV_OUT);

  // ==========================================================================
  // Double-buffered divider settings
  // ==========================================================================
  // The upper reference bits and the feedback word wait for register 0, so a
  // feedback retune lands in one step; the lower reference bits follow register 2 at once.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_divider  <= '0;
      feedback_int <= '0;
      fraction     <= '0;
    end else if (reg0_write) begin
      ref_divider  <= {reg_int_phase[RHI_HI:RHI_LO], reg_ref_pump[RLO_HI:RLO_LO]};
      feedback_int <= {reg_int_phase[NHI_HI:NHI_LO], shift_word[NLO_HI:NLO_LO]};
      fraction     <= shift_word[FRAC_HI:FRAC_LO];
    end else begin
      ref_divider[RLO_HI-RLO_LO:0] <= reg_ref_pump[RLO_HI:RLO_LO];
    end
  end

  // ==========================================================================
  // Static control outputs
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shutdown             <= 1'b1;
      ref_input_hiz        <= 1'b1;
      counter_hold         <= 1'b0;
      integer_mode         <= 1'b0;
      lock_detect_type     <= 1'b0;
      pump_hiz             <= 1'b0;
      detector_polarity    <= 1'b0;
      pump_clamp           <= 1'b0;
      modulator_noise_mode <= '0;
      reference_doubler    <= 1'b0;
      reference_halver     <= 1'b0;
      phase_value          <= '0;
      converter_clock_en   <= 1'b0;
    end else begin
      shutdown      <= reg_mode_pump[SOFT_POWERDOWN_BIT] || !lvl[PIN_CE];
      ref_input_hiz <= reg_mode_pump[SOFT_POWERDOWN_BIT] || !lvl[PIN_CE];
      counter_hold  <= reg_mode_pump[HOLD_BIT];
      integer_mode  <= reg_mode_pump[INTSEL_BIT] ||
                       (reg_timer_conv[AUTOINT_BIT] && fraction == '0);
      lock_detect_type     <= reg_mode_pump[LDTYPE_BIT];
      pump_hiz             <= reg_mode_pump[TRI_BIT];
      detector_polarity    <= reg_mode_pump[POL_BIT];
      pump_clamp           <= reg_mode_pump[CLAMP_BIT];
      modulator_noise_mode <= reg_ref_pump[NOISE_HI:NOISE_LO];
      reference_doubler    <= reg_ref_pump[RDBL_BIT];
      reference_halver     <= reg_ref_pump[RHALF_BIT];
      phase_value          <= reg_int_phase[PHASE_HI:PHASE_LO];
      converter_clock_en   <= (dmode == DMODE_CONV);
    end
  end

  // ==========================================================================
  // Fast lock timer
  // ==========================================================================
  logic [11:0] fast_count;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fast_lock_active <= 1'b0;
      fast_count       <= '0;
    end else if (reg0_write && dmode == DMODE_FAST &&
                 reg_ref_pump[PUMP_HI:PUMP_LO] == PUMP_MIN &&
                 shift_word[OSEL_HI:OSEL_LO] == OSEL_FAST) begin
      fast_lock_active <= (dval != '0);
      fast_count       <= dval;
    end else if (fast_lock_active && tick) begin
      fast_count       <= fast_count - 12'h001;
      fast_lock_active <= (fast_count != 12'h001);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pump_current_code <= '0;
    end else if (fast_lock_active) begin
      pump_current_code <= PUMP_MAX;
    end else begin
      pump_current_code <= reg_ref_pump[PUMP_HI:PUMP_LO];
    end
  end

  // ==========================================================================
  // Digital lock detect
  // ==========================================================================
  logic [5:0] lock_run;
  logic [5:0] lock_need;

  assign lock_need = lock_detect_type ? LOCK_RUN_INT : LOCK_RUN_FRAC;

  // The skew comparison itself is analog; this counts its per-cycle verdicts.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_run    <= '0;
      lock_detect <= 1'b0;
    end else if (counter_hold || shutdown) begin
      lock_run    <= '0;
      lock_detect <= 1'b0;
    end else if (tick) begin
      if (!lvl[PIN_LOCKED]) begin
        lock_run    <= '0;
        lock_detect <= 1'b0;
      end else if (lock_run + 6'h01 >= lock_need) begin
        lock_run    <= lock_need;
        lock_detect <= 1'b1;
      end else begin
        lock_run <= lock_run + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_window_ns   <= WIN_WIDE_NS;
      unlock_window_ns <= UNLOCK_SLOW_NS;
    end else if (reg_ref_pump[LSPEED_BIT]) begin
      lock_window_ns   <= WIN_FAST_NS;
      unlock_window_ns <= WIN_FAST_NS;
    end else begin
      lock_window_ns   <= reg_ref_pump[LPREC_BIT] ? WIN_NARROW_NS : WIN_WIDE_NS;
      unlock_window_ns <= UNLOCK_SLOW_NS;
    end
  end

  // ==========================================================================
  // Phase synchronisation
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      divider_resync <= 1'b0;
      phase_apply    <= 1'b0;
    end else begin
      divider_resync <= (osel == OSEL_SYNC) && rise[PIN_MUX];
      phase_apply    <= commit && ssc_write_hit(shift_word, ADDR_TIMER_CONV) &&
                        shift_word[DMODE_HI:DMODE_LO] == DMODE_PHASE;
    end
  end

  // ==========================================================================
  // Temperature converter sequence
  // ==========================================================================
  logic [15:0] conv_count;

  // The sensor code is settled long before the conversion time runs out, so it
  // is captured without a synchroniser.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      converter_busy <= 1'b0;
      conv_count     <= '0;
      reg_conv_rb    <= '0;
    end else if (!converter_busy) begin
      if (converter_clock_en && reg_timer_conv[CSTART_BIT] &&
          reg_timer_conv[CMODE_HI:CMODE_LO] == CMODE_TEMP) begin
        converter_busy <= 1'b1;
        conv_count     <= 16'(CONV_CYCLES);
      end
    end else if (!converter_clock_en) begin
      converter_busy <= 1'b0;
    end else if (conv_count == 16'h0001) begin
      converter_busy <= 1'b0;
      reg_conv_rb    <= '0;
      reg_conv_rb[TEMP_HI:TEMP_LO] <= temp_code;
      reg_conv_rb[ADDR_HI:0]       <= ADDR_CONV_RB;
    end else begin
      conv_count <= conv_count - 16'h0001;
    end
  end

  // ==========================================================================
  // Serial readback
  // ==========================================================================
  ssc_rb_t             rb_state;
  logic [PAYLOAD_W-1:0] rb_shift;
  logic [4:0]          rb_count;
  logic                rb_bit;
  logic [WORD_W-1:0]   rb_source;

  always_comb begin
    unique case (shift_word[ADDR_HI:0])
      ADDR_DIV_OUT:    rb_source = reg_div_out;
      ADDR_INT_PHASE:  rb_source = reg_int_phase;
      ADDR_REF_PUMP:   rb_source = reg_ref_pump;
      ADDR_MODE_PUMP:  rb_source = reg_mode_pump;
      ADDR_TIMER_CONV: rb_source = reg_timer_conv;
      ADDR_CONV_RB:    rb_source = reg_conv_rb;
      default:         rb_source = '0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rb_state <= RB_IDLE;
      rb_shift <= '0;
      rb_count <= '0;
      rb_bit   <= 1'b0;
    end else if (commit && shift_word[READ_BIT] && osel == OSEL_RDBACK) begin
      rb_state <= RB_ARMED;
      rb_shift <= rb_source[WORD_W-1:ADDR_HI+1];
      rb_count <= '0;
    end else if (sclk_rise) begin
      unique case (rb_state)
        RB_IDLE: begin
        end
        RB_ARMED: begin
          rb_bit   <= rb_shift[PAYLOAD_W-1];
          rb_shift <= {rb_shift[PAYLOAD_W-2:0], 1'b0};
          rb_state <= RB_SHIFT;
        end
        RB_SHIFT: begin
          rb_bit   <= rb_shift[PAYLOAD_W-1];
          rb_shift <= {rb_shift[PAYLOAD_W-2:0], 1'b0};
          rb_count <= rb_count + 5'h01;
          if (rb_count == RB_LAST - 5'h01) begin
            rb_state <= RB_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Multipurpose pin
  // ==========================================================================
  logic next_mux_out;
  logic next_mux_oe;

  always_comb begin
    next_mux_out = 1'b0;
    next_mux_oe  = 1'b1;
    unique case (osel)
      OSEL_HIGH:   next_mux_out = 1'b1;
      OSEL_LOW:    next_mux_out = 1'b0;
      OSEL_RDIV:   next_mux_out = lvl[PIN_RDIV] && !counter_hold;
      OSEL_NDIV:   next_mux_out = lvl[PIN_NDIV] && !counter_hold;
      OSEL_ALOCK:  next_mux_out = lvl[PIN_ALOCK];
      OSEL_DLOCK:  next_mux_out = lock_detect;
      OSEL_RDBACK: next_mux_out = rb_bit;
      OSEL_SYNC:   next_mux_oe  = 1'b0;
      OSEL_FAST:   next_mux_oe  = fast_lock_active;
      OSEL_RHALF:  next_mux_out = lvl[PIN_RDIV] && !counter_hold;
      default:     next_mux_oe  = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mux_out <= 1'b0;
      mux_oe  <= 1'b0;
    end else begin
      mux_out <= next_mux_out;
      mux_oe  <= next_mux_oe && !shutdown;
    end
  end

endmodule : ssc_serial_control

// >>> rtl/ssc_sync.sv
// Two-stage pin synchroniser with a rising-edge marker.
module ssc_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic       meta;
  logic       stage;
  logic       prev;
  logic [2:0] fill;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta  <= 1'b0;
      stage <= 1'b0;
      prev  <= 1'b0;
      fill  <= '0;
    end else begin
      meta  <= pin;
      stage <= meta;
      prev  <= stage;
      fill  <= {fill[1:0], 1'b1};
    end
  end

  // The marker waits until the chain holds real pin samples, so a pin that
  // idles high does not fake an edge just after reset.
  assign level = stage;
  assign rise  = stage & ~prev & fill[2];

endmodule : ssc_sync

// >>> tb/ssc_host.sv
// Host controller model driving the serial programming pins.
module ssc_host (
  input  wire logic clk,
  input  wire logic mux_out,
  output logic      sclk,
  output logic      sdata,
  output logic      strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
    strobe = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  // Four cycles per level give the two-flop synchronisers margin.
  task automatic send(input logic [35:0] v, input int n);
    hold(1);
    strobe <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdata <= v[i];
      hold(4);
      sclk <= 1'b1;
      hold(4);
      sclk <= 1'b0;
    end
    hold(4);
    strobe <= 1'b1;
    sdata <= ~v[0];
    hold(12);
  endtask : send
  // Strobe stays high while reading so no stray word is committed.
  task automatic fetch(input logic [2:0] a, output logic [28:0] r);
    send({5'h01, 28'hfffffff, a}, 32);
    for (int i = 28; i >= 0; i--) begin
      sclk <= 1'b1;
      hold(4);
      sclk <= 1'b0;
      hold(3);
      @(negedge clk);
      r[i] = mux_out;
      hold(1);
    end
  endtask : fetch
endmodule : ssc_host

// >>> tb/ssc_serial_control_assertions.sv
// Port-level checks of the serial control block.
module ssc_checker (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       shutdown,
  input wire logic       ref_input_hiz,
  input wire logic       mux_oe,
  input wire logic       mux_out,
  input wire logic       counter_hold,
  input wire logic       lock_detect,
  input wire logic       fast_lock_active,
  input wire logic [3:0] pump_current_code,
  input wire logic [3:0] lock_window_ns,
  input wire logic [3:0] unlock_window_ns
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  chk_soft_powerdown_pair: assert property (shutdown == ref_input_hiz)
    else $error("shutdown and reference hiz differ");
  chk_soft_powerdown_pin: assert property (shutdown && $past(shutdown) |-> !mux_oe)
    else $error("pin driven in shutdown");
  chk_soft_powerdown_lock: assert property (shutdown && $past(shutdown) |-> !lock_detect)
    else $error("lock shown in shutdown");
  chk_hold_lock: assert property (counter_hold && $past(counter_hold) |-> !lock_detect)
    else $error("lock shown while counters held");
  chk_fast_pump: assert property (fast_lock_active && $past(fast_lock_active) |->
    pump_current_code == 4'hf)
    else $error("pump not at maximum in fast lock");
  chk_fast_pin: assert property (fast_lock_active && $past(fast_lock_active) |->
    mux_oe && !mux_out)
    else $error("pin not grounded in fast lock");
  chk_win_pair: assert property ((lock_window_ns == 4'h4) == (unlock_window_ns == 4'h4))
    else $error("lock windows disagree on speed");
  chk_win_vals: assert property (lock_window_ns inside {4'h4, 4'h6, 4'ha} &&
    unlock_window_ns inside {4'h4, 4'hf})
    else $error("lock window value out of set");
endmodule : ssc_checker

bind ssc_serial_control ssc_checker u_ssc_checker (.clk, .resetn, .shutdown, .ref_input_hiz,
  .mux_oe, .mux_out, .counter_hold, .lock_detect, .fast_lock_active, .pump_current_code,
  .lock_window_ns, .unlock_window_ns);

// >>> tb/ssc_serial_control_tb.sv
// Self-checking bench for the serial control block.
module ssc_serial_control_tb
  import ssc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, chip_enable, detector_tick, phase_locked, sclk, sdata, strobe;
  logic shutdown, ref_input_hiz, counter_hold, integer_mode, lock_detect_type, pump_hiz;
  logic detector_polarity, pump_clamp, lock_detect, fast_lock_active, mux_out, mux_oe, conv_en;
  logic [3:0]  pump_current_code;
  logic [1:0]  modulator_noise_mode;
  logic [9:0]  ref_divider;
  logic [15:0] feedback_int;
  logic [11:0] fraction;
  logic [6:0]  temp_code;
  logic [28:0] rb;
  int          error_cnt = 0;
  int          n_tests = 0;
  logic [31:0] w2 [4] = '{32'h00000002, 32'h40000002, 32'h60000002, 32'h05000002};
  logic [31:0] w3 [4] = '{32'h00000003, 32'h00002603, 32'h00000053, 32'h0000000b};
  logic [7:0]  exp_obs [4] = '{8'h00, 8'hb8, 8'hc6, 8'h01};
  wire  [7:0]  obs = {modulator_noise_mode, pump_clamp, integer_mode, lock_detect_type,
                      detector_polarity, pump_hiz, counter_hold};
  wire  [6:0]  fast_obs = {fast_lock_active, pump_current_code, mux_oe, mux_out};

  ssc_host u_ssc_host (.clk, .mux_out, .sclk, .sdata, .strobe);

  ssc_serial_control #(.CONV_CYCLES(20)) u_ssc_serial_control (
    .clk, .resetn, .serial_clock(sclk), .serial_data(sdata), .load_strobe(strobe),
    .chip_enable, .mux_in(1'b0), .mux_out, .mux_oe, .detector_tick, .phase_locked,
    .ref_div_in(1'b0), .fb_div_in(1'b0), .analog_lock(1'b0), .temp_code,
    .shutdown, .ref_input_hiz, .counter_hold, .integer_mode, .lock_detect_type, .pump_hiz,
    .detector_polarity, .pump_clamp, .pump_current_code, .modulator_noise_mode,
    .reference_doubler(), .reference_halver(), .ref_divider, .feedback_int, .fraction,
    .phase_value(), .phase_apply(), .divider_resync(), .converter_clock_en(conv_en),
    .converter_busy(), .lock_detect, .lock_window_ns(), .unlock_window_ns(), .fast_lock_active
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    detector_tick = 1'b0;
    forever begin
      repeat (4) @(posedge clk);
      detector_tick <= ~detector_tick;
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      error_cnt++;
    end
  endtask : check
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    chip_enable = 1'b1;
    temp_code = 7'h5a;
    phase_locked = 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 4; a >= 0; a--) u_ssc_host.send({33'h0, a[2:0]}, 32);
    wt(2);
    check("shutdown", 0, shutdown);
    done("power-up");
    for (int i = 0; i < 4; i++) begin
      u_ssc_host.send({4'h0, w2[i]}, 32);
      u_ssc_host.send({4'h0, w3[i]}, 32);
      wt(2);
      check("controls", exp_obs[i], obs);
    end
    done("rows");
    u_ssc_host.send(36'h0000a8001, 32);
    wt(2);
    check("ref early", 0, ref_divider);
    u_ssc_host.send(36'h038918000, 32);
    wt(2);
    check("ref div", 10'h2a0, ref_divider);
    check("feedback", 16'h0123, feedback_int);
    // Four junk bits lead the word; only the last 32 may count.
    u_ssc_host.send(36'ha20000004, 36);
    wt(2);
    check("auto int", 1, integer_mode);
    done("buffering");
    u_ssc_host.send(36'h07ffffff5, 32);
    u_ssc_host.fetch(3'h5, rb);
    check("unmapped", 0, rb);
    u_ssc_host.fetch(3'h3, rb);
    check("readback", 29'h1, rb);
    check("hold kept", 1, counter_hold);
    done("readback");
    @(posedge clk) chip_enable <= 1'b0;
    wt(8);
    check("pin off", 1, shutdown);
    @(posedge clk) chip_enable <= 1'b1;
    u_ssc_host.send(36'h23, 32);
    wt(2);
    check("soft off", 1, shutdown);
    done("shutdown");
    u_ssc_host.send(36'h603, 32);
    @(posedge clk) phase_locked <= 1'b1;
    wt(24);
    check("early lock", 0, lock_detect);
    wt(40);
    check("lock", 1, lock_detect);
    @(posedge clk) phase_locked <= 1'b0;
    wt(20);
    check("unlock", 0, lock_detect);
    done("lock");
    u_ssc_host.send(36'h000080404, 32);
    u_ssc_host.send(36'h2, 32);
    u_ssc_host.send(36'h060918000, 32);
    wt(0);
    check("fast", {1'b1, PUMP_MAX, 2'b10}, fast_obs);
    wt(80);
    check("fast end", 0, fast_obs[6:2]);
    done("fast lock");
    // The bench runs the converter with a short conversion time, so one word
    // on the link is already far longer than the wait that the host owes.
    u_ssc_host.send(36'h00018001c, 32);
    u_ssc_host.send(36'h038918000, 32);
    check("conv clock", 1, conv_en);
    u_ssc_host.fetch(3'h6, rb);
    check("temp", 29'h5a, rb);
    done("converter");
    tally_and_finish();
  end
endmodule : ssc_serial_control_tb
